//--- design/gvb_core.sv
// digital core of an eleven-channel reference DAC: bank storage, direct codes, two-stage latch, two-wire slave
// assumes clk far faster than scl; pins are asynchronous and synchronised here; sda is open drain outside
//
// Contract
// - control bits pick mode: 00 pin banks, 01 register banks, 1x direct channel control.
// - mode control bits reset to zero, so pin-selected bank mode comes first.
// - four bank bytes per channel; select 00..11 picks bank A..D for all channels.
// - pin-selected mode takes bank select from the two bank select pins.
// - load strobe high makes second-stage latch transparent to the selected source.
// - load strobe low holds second-stage latch whatever source or selection does.
// - load strobe rising edge passes latch input to all DACs.
// - load strobe falling edge captures the selected data and keeps it.
// - register-selected mode takes bank select from soft bank bits 1:0; pins ignored.
// - soft bank bits clear to zero at power-up, giving bank A.
// - direct mode writes eleven volatile first-stage bytes at 00..0A, no write delay.
// - direct mode: strobe high passes writes at once; low waits for rising edge.
// - each channel drives an 8-bit code; high gamma channels read code inverted.
// - standby bit set floats all outputs; cleared restores drive.
// - bus keeps answering reads and writes during standby.
// - over-temperature floats the common-electrode buffer until the indication clears.
// - address byte is 7-bit address plus read/write; one bit follows address pin.
// - address pin grounded answers address byte C0h.
// - bank bytes at 10..3B, four per channel, common channel first then gamma 1..10.
// - read-only status: load strobe in bit 7, bank pins in bits 1 and 0.
// - non-volatile write time starts only after the stop ending the transaction.
`timescale 1ns/1ps
`include "gvb_map.svh"

module gvb_core
  import gvb_pkg::*;
#(
  parameter int NV_WRITE_CYCLES = `GVB_NV_WRITE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // asynchronous pins
  input wire logic load_strobe,
  input wire logic bank_select_pin_high,
  input wire logic bank_select_pin_low,
  input wire logic address_select_pin,
  input wire logic over_temp,
  // two-wire bus
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // dac side
  output logic [`GVB_NUM_CHAN-1:0][7:0] dac_code,
  output logic [`GVB_NUM_CHAN-1:0] chan_drive_en,
  output logic nv_busy
);

  localparam int BANK_BYTES = `GVB_NUM_CHAN * `GVB_NUM_BANK;

  gvb_pins_type pins_raw;
  gvb_pins_type pins_meta;
  gvb_pins_type pins_sync;
  gvb_pins_type pins_prev;

  // bus state
  gvb_bus_state_type bus_state, next_bus_state;
  logic [7:0] shift, next_shift;
  logic [7:0] tx, next_tx;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] ptr, next_ptr;
  logic have_ptr, next_have_ptr;
  logic rw, next_rw;
  logic oe, next_oe;
  logic nv_dirty, next_nv_dirty;
  logic [31:0] busy_cnt, next_busy_cnt;
  logic busy, next_busy;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;

  // register state
  logic [7:0] direct [`GVB_NUM_CHAN];
  logic [7:0] next_direct [`GVB_NUM_CHAN];
  logic [7:0] bank [BANK_BYTES];
  logic [7:0] next_bank [BANK_BYTES];
  logic [1:0] soft_bank, next_soft_bank;
  logic standby, next_standby;
  logic [7:0] mode_ctl, next_mode_ctl;

  // output latch state
  logic [7:0] latch_b [`GVB_NUM_CHAN];
  logic [7:0] next_latch_b [`GVB_NUM_CHAN];
  logic [`GVB_NUM_CHAN-1:0] drive, next_drive;

  logic scl_rise, scl_fall, start_seen, stop_seen;
  logic [7:0] rd_data;
  logic [1:0] sel;
  logic [5:0] bank_idx;
  logic [7:0] bank_ofs;
  logic load_rise, load_fall;

  assign pins_raw = '{load_strobe, bank_select_pin_high, bank_select_pin_low, scl, sda_in,
                      address_select_pin, over_temp};

  // two-flop synchroniser, then one more stage for edge detection
  always_ff @(posedge clk) begin
    if (rst) begin
      pins_meta <= '0;
      pins_sync <= '0;
      pins_prev <= '0;
    end else begin
      pins_meta <= pins_raw;
      pins_sync <= pins_meta;
      pins_prev <= pins_sync;
    end
  end

  // bus line events from synchronised levels only
  assign scl_rise = pins_sync.scl & ~pins_prev.scl;
  assign scl_fall = ~pins_sync.scl & pins_prev.scl;
  assign start_seen = pins_sync.scl & pins_prev.scl & pins_prev.sda & ~pins_sync.sda;
  assign stop_seen = pins_sync.scl & pins_prev.scl & ~pins_prev.sda & pins_sync.sda;
  assign load_rise = pins_sync.load_strobe & ~pins_prev.load_strobe;
  assign load_fall = ~pins_sync.load_strobe & pins_prev.load_strobe;

  // read multiplexer over the register map
  assign bank_ofs = ptr - `GVB_OFS_BANK;
  assign bank_idx = bank_ofs[5:0];
  always_comb begin
    rd_data = 8'h00;
    if (ptr <= `GVB_OFS_DIRECT_LAST) begin
      rd_data = direct[ptr[3:0]];
    end else if (ptr >= `GVB_OFS_BANK && ptr <= `GVB_OFS_BANK_LAST) begin
      rd_data = bank[bank_idx];
    end else if (ptr == `GVB_OFS_SOFT_BANK) begin
      rd_data = {6'h00, soft_bank};
    end else if (ptr == `GVB_OFS_STANDBY) begin
      rd_data = {7'h00, standby};
    end else if (ptr == `GVB_OFS_STATUS) begin
      rd_data = {pins_sync.load_strobe, 5'h00, pins_sync.bank_select_pin_high,
                 pins_sync.bank_select_pin_low};
    end else if (ptr == `GVB_OFS_MODE) begin
      rd_data = mode_ctl;
    end
  end

  // two-wire slave: address, pointer, write and read phases; standby has no effect here
  always_comb begin
    next_bus_state = bus_state;
    next_shift = shift;
    next_tx = tx;
    next_bit_cnt = bit_cnt;
    next_ptr = ptr;
    next_have_ptr = have_ptr;
    next_rw = rw;
    next_oe = oe;
    next_nv_dirty = nv_dirty;
    next_busy_cnt = busy_cnt;
    next_busy = busy;
    wr_en = 1'b0;
    wr_addr = ptr;
    wr_data = shift;
    if (busy) begin
      if (busy_cnt == 32'h0) begin
        next_busy = 1'b0;
      end else begin
        next_busy_cnt = busy_cnt - 32'h1;
      end
    end
    if (scl_rise && bus_state != GVB_IDLE) begin
      next_shift = {shift[6:0], pins_sync.sda};
      next_bit_cnt = bit_cnt + 4'h1;
    end
    if (start_seen) begin
      next_bus_state = GVB_ADDR;
      next_bit_cnt = 4'h0;
      next_oe = 1'b0;
    end else if (stop_seen) begin
      next_bus_state = GVB_IDLE;
      next_oe = 1'b0;
      if (nv_dirty) begin
        next_nv_dirty = 1'b0;
        next_busy = 1'b1;
        next_busy_cnt = 32'(NV_WRITE_CYCLES - 1);
      end
    end else if (scl_fall) begin
      unique case (bus_state)
        GVB_IDLE: begin
        end
        GVB_ADDR: begin
          if (bit_cnt == 4'h8) begin
            // own address; the pin lands in address byte bit 1
            if (shift[7:1] == {`GVB_SLAVE_ADDR_HIGH, pins_sync.address_select_pin} && !busy) begin
              next_oe = 1'b1;
              next_rw = shift[0];
              next_bus_state = GVB_ADDR_ACK;
            end else begin
              next_bus_state = GVB_IDLE;
            end
          end
        end
        GVB_ADDR_ACK: begin
          next_bit_cnt = 4'h0;
          next_have_ptr = 1'b0;
          if (rw) begin
            next_tx = rd_data;
            next_oe = ~rd_data[7];
            next_bus_state = GVB_READ;
          end else begin
            next_oe = 1'b0;
            next_bus_state = GVB_WRITE;
          end
        end
        GVB_WRITE: begin
          if (bit_cnt == 4'h8) begin
            next_oe = 1'b1;
            next_bus_state = GVB_WRITE_ACK;
            if (!have_ptr) begin
              next_ptr = shift;
              next_have_ptr = 1'b1;
            end else begin
              wr_en = 1'b1;
              next_ptr = ptr + 8'h1;
              if ((ptr >= `GVB_OFS_BANK && ptr <= `GVB_OFS_BANK_LAST) || ptr == `GVB_OFS_MODE) begin
                next_nv_dirty = 1'b1;
              end
            end
          end
        end
        GVB_WRITE_ACK: begin
          next_oe = 1'b0;
          next_bit_cnt = 4'h0;
          next_bus_state = GVB_WRITE;
        end
        GVB_READ: begin
          if (bit_cnt == 4'h8) begin
            next_oe = 1'b0;
            next_ptr = ptr + 8'h1;
            next_bus_state = GVB_READ_ACK;
          end else begin
            next_tx = {tx[6:0], 1'b0};
            next_oe = ~tx[6];
          end
        end
        GVB_READ_ACK: begin
          next_bit_cnt = 4'h0;
          if (!shift[0]) begin
            next_tx = rd_data;
            next_oe = ~rd_data[7];
            next_bus_state = GVB_READ;
          end else begin
            next_bus_state = GVB_IDLE;
          end
        end
      endcase
    end
  end

  // bus registers
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_state <= GVB_IDLE;
      shift <= 8'h00;
      tx <= 8'h00;
      bit_cnt <= 4'h0;
      ptr <= 8'h00;
      have_ptr <= 1'b0;
      rw <= 1'b0;
      oe <= 1'b0;
      nv_dirty <= 1'b0;
      busy_cnt <= 32'h0;
      busy <= 1'b0;
    end else begin
      bus_state <= next_bus_state;
      shift <= next_shift;
      tx <= next_tx;
      bit_cnt <= next_bit_cnt;
      ptr <= next_ptr;
      have_ptr <= next_have_ptr;
      rw <= next_rw;
      oe <= next_oe;
      nv_dirty <= next_nv_dirty;
      busy_cnt <= next_busy_cnt;
      busy <= next_busy;
    end
  end

  // register file writes
  always_comb begin
    next_direct = direct;
    next_bank = bank;
    next_soft_bank = soft_bank;
    next_standby = standby;
    next_mode_ctl = mode_ctl;
    if (wr_en) begin
      if (wr_addr <= `GVB_OFS_DIRECT_LAST) begin
        next_direct[wr_addr[3:0]] = wr_data;
      end else if (wr_addr >= `GVB_OFS_BANK && wr_addr <= `GVB_OFS_BANK_LAST) begin
        next_bank[bank_idx] = wr_data;
      end else if (wr_addr == `GVB_OFS_SOFT_BANK) begin
        next_soft_bank = wr_data[1:0];
      end else if (wr_addr == `GVB_OFS_STANDBY) begin
        next_standby = wr_data[`GVB_STANDBY_BIT];
      end else if (wr_addr == `GVB_OFS_MODE) begin
        next_mode_ctl = wr_data;
      end
    end
  end

  // register file storage; non-volatile bytes take their delivered values at reset
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < `GVB_NUM_CHAN; i++) begin
        direct[i] <= `GVB_RST_DIRECT;
      end
      for (int i = 0; i < BANK_BYTES; i++) begin
        bank[i] <= `GVB_RST_BANK;
      end
      soft_bank <= `GVB_RST_SOFT_BANK;
      standby <= `GVB_RST_STANDBY;
      mode_ctl <= `GVB_RST_MODE;
    end else begin
      direct <= next_direct;
      bank <= next_bank;
      soft_bank <= next_soft_bank;
      standby <= next_standby;
      mode_ctl <= next_mode_ctl;
    end
  end

  // bank select source by mode
  assign sel = mode_ctl[`GVB_MODE_BIT_LOW] ? soft_bank
             : {pins_sync.bank_select_pin_high, pins_sync.bank_select_pin_low};

  // second-stage latch and output enables, one lane per channel
  genvar ch;
  generate
    for (ch = 0; ch < `GVB_NUM_CHAN; ch++) begin : g_chan
      logic [7:0] src;
      // direct mode ignores the low control bit
      assign src = mode_ctl[`GVB_MODE_BIT_HIGH] ? direct[ch]
                 : bank[ch * `GVB_NUM_BANK + int'(sel)];
      always_comb begin
        next_latch_b[ch] = latch_b[ch];
        if (pins_sync.load_strobe || load_rise || load_fall) begin
          next_latch_b[ch] = src;
        end
        next_drive[ch] = ~standby;
        if (ch == 0 && pins_sync.over_temp) begin
          next_drive[ch] = 1'b0;
        end
      end
      always_ff @(posedge clk) begin
        if (rst) begin
          latch_b[ch] <= `GVB_RST_DIRECT;
          drive[ch] <= 1'b0;
        end else begin
          latch_b[ch] <= next_latch_b[ch];
          drive[ch] <= next_drive[ch];
        end
      end
      // raw code; the inverted sense of the high gamma lanes lives in the analog ladder
      assign dac_code[ch] = latch_b[ch];
    end
  endgenerate

  // open-drain data line: level always low, enable pulls it
  always_ff @(posedge clk) begin
    if (rst) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  assign sda_oe = oe;
  assign chan_drive_en = drive;
  assign nv_busy = busy;

endmodule // gvb_core

//--- shared/gvb_map.svh
// register offsets, field positions, reset values and bus constants of the gamma/common bank core
// assumes byte-wide registers reached through the two-wire slave only
`ifndef GVB_MAP_SVH
`define GVB_MAP_SVH
`define GVB_NUM_CHAN 11
`define GVB_NUM_BANK 4
`define GVB_OFS_DIRECT 8'h00
`define GVB_OFS_DIRECT_LAST 8'h0A
`define GVB_OFS_BANK 8'h10
`define GVB_OFS_BANK_LAST 8'h3B
`define GVB_OFS_SOFT_BANK 8'h50
`define GVB_OFS_STANDBY 8'h51
`define GVB_OFS_STATUS 8'h57
`define GVB_OFS_MODE 8'h60
`define GVB_MODE_BIT_LOW 0
`define GVB_MODE_BIT_HIGH 1
`define GVB_STANDBY_BIT 0
`define GVB_STATUS_LOAD_BIT 7
`define GVB_RST_DIRECT 8'h00
`define GVB_RST_BANK 8'h80
`define GVB_RST_SOFT_BANK 2'h0
`define GVB_RST_STANDBY 1'h0
`define GVB_RST_MODE 8'h10
`define GVB_SLAVE_ADDR_HIGH 6'h30
`define GVB_NV_WRITE_CYCLES 1000
`endif

//--- shared/gvb_pkg.sv
// types shared by the gamma/common bank core
// assumes the constants of gvb_map.svh
package gvb_pkg;
  typedef enum logic [2:0] {
    GVB_IDLE, GVB_ADDR, GVB_ADDR_ACK, GVB_WRITE, GVB_WRITE_ACK, GVB_READ, GVB_READ_ACK
  } gvb_bus_state_type;

  // pins that arrive from outside the clock domain
  typedef struct packed {
    logic load_strobe;
    logic bank_select_pin_high;
    logic bank_select_pin_low;
    logic scl;
    logic sda;
    logic address_select_pin;
    logic over_temp;
  } gvb_pins_type;

  typedef logic [7:0] gvb_byte_type;
endpackage

//--- tb/gvb_master.sv
// two-wire bus master model: drives scl, pulls sda low; 160 ns bit time at 50 MHz
// assumes the testbench resolves sda with a pull-up
`timescale 1ns/1ps
module gvb_master (
  // clock
  input wire logic clk,
  // bus
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // wait n clock edges
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one bit: data set in scl low, sampled while scl high
  task automatic bit_io(input logic b, output logic r);
    sda_low <= !b;
    tk(4);
    scl <= 1'b1;
    tk(2);
    r = sda;
    tk(1);
    scl <= 1'b0;
    tk(1);
  endtask

  // start or repeated start: sda falls while scl high
  task automatic start;
    sda_low <= 1'b0;
    tk(4); // let the slave drop its ack before scl rises
    scl <= 1'b1;
    tk(4);
    sda_low <= 1'b1;
    tk(4);
    scl <= 1'b0;
    tk(1);
  endtask

  // stop: sda rises while scl high, then bus left free
  task automatic stop;
    sda_low <= 1'b1;
    tk(2);
    scl <= 1'b1;
    tk(4);
    sda_low <= 1'b0;
    tk(4);
  endtask

  // eight bits msb first, then the ninth bit; a_in high releases sda
  task automatic xfer(input logic [7:0] d, input logic a_in, output logic [7:0] q, output logic a_out);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a_in, r);
    a_out = !r;
  endtask

  // address, pointer, one data byte; ok reports the address ack
  task automatic wr(input logic [7:0] dev, input logic [7:0] p, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic a;
    start();
    xfer(dev, 1'b1, q, ok);
    xfer(p, 1'b1, q, a);
    xfer(d, 1'b1, q, a);
    stop();
  endtask

  // pointer write, repeated start, one byte read ending in a nack
  task automatic rd(input logic [7:0] dev, input logic [7:0] p, output logic [7:0] q);
    logic [7:0] x;
    logic a;
    start();
    xfer(dev, 1'b1, x, a);
    xfer(p, 1'b1, x, a);
    start();
    xfer(dev | 8'h01, 1'b1, x, a);
    xfer(8'hFF, 1'b1, q, a);
    stop();
  endtask
endmodule // gvb_master

//--- tb/gvb_monitor.sv
// checker of gvb_core port behaviour, bound into every instance
// assumes one clock domain and synchronous reset
`timescale 1ns/1ps
`include "gvb_map.svh"
module gvb_checker #(
  parameter int NV_WRITE_CYCLES = `GVB_NV_WRITE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pins
  input wire logic load_strobe,
  input wire logic bank_select_pin_high,
  input wire logic bank_select_pin_low,
  input wire logic address_select_pin,
  input wire logic over_temp,
  // bus
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // dac side
  input wire logic [`GVB_NUM_CHAN-1:0][7:0] dac_code,
  input wire logic [`GVB_NUM_CHAN-1:0] chan_drive_en,
  input wire logic nv_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  int busy_cnt;
  int next_busy_cnt;

  // length of the current non-volatile write
  always_comb begin
    next_busy_cnt = nv_busy ? busy_cnt + 1 : 0;
  end
  always_ff @(posedge clk) begin
    busy_cnt <= rst ? 0 : next_busy_cnt;
  end

  sequence s_low_run;
    (!load_strobe)[*6];
  endsequence
  sequence s_hot_run;
    over_temp[*4];
  endsequence
  sequence s_cool_run;
    (!over_temp)[*4];
  endsequence

  a_strobe_hold: assert property (s_low_run |-> $stable(dac_code))
    else $error("dac code moved while strobe low");
  a_gamma_together: assert property (chan_drive_en[10:1] == '0 || chan_drive_en[10:1] == '1)
    else $error("gamma drive enables differ");
  a_vcom_needs_drive: assert property (chan_drive_en[0] |-> chan_drive_en[1])
    else $error("common channel driven in standby");
  a_hot_vcom_off: assert property (s_hot_run |-> !chan_drive_en[0])
    else $error("common channel driven while hot");
  a_cool_vcom_on: assert property (s_cool_run |-> chan_drive_en[0] == chan_drive_en[1])
    else $error("common channel off while cool");
  a_oe_scl_high: assert property (scl && $past(scl) |-> $stable(sda_oe))
    else $error("sda drive changed while scl high");
  a_sda_level_low: assert property (sda_oe |-> !sda_out)
    else $error("sda driven high by the slave");
  a_busy_length: assert property ($fell(nv_busy) |-> busy_cnt == NV_WRITE_CYCLES)
    else $error("write time length wrong");
  a_busy_no_ack: assert property ($rose(sda_oe) |-> !nv_busy)
    else $error("ack given during write time");
  a_busy_after_stop: assert property ($rose(nv_busy) |-> scl && sda_in)
    else $error("write time began before stop");
endmodule // gvb_checker

bind gvb_core gvb_checker #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) mon (
  .clk(clk), .rst(rst), .load_strobe(load_strobe), .bank_select_pin_high(bank_select_pin_high),
  .bank_select_pin_low(bank_select_pin_low), .address_select_pin(address_select_pin),
  .over_temp(over_temp), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .dac_code(dac_code), .chan_drive_en(chan_drive_en), .nv_busy(nv_busy));

//--- tb/testbench.sv
// bench of gvb_core: banks, latch, soft select, direct codes, standby, thermal, address
// assumes gvb_master drives the bus and sda has a pull-up
`timescale 1ns/1ps
`include "gvb_map.svh"
module testbench;
  import gvb_pkg::*;
  localparam int NVW = 200;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic load_strobe = 1'b1;
  logic [1:0] sel = 2'h0;
  logic address_select_pin = 1'b0;
  logic over_temp = 1'b0;
  logic scl;
  logic sda_low;
  logic sda_out;
  logic sda_oe;
  logic [`GVB_NUM_CHAN-1:0][7:0] dac_code;
  logic [`GVB_NUM_CHAN-1:0] chan_drive_en;
  logic nv_busy;
  logic [7:0] dev = 8'hC0;
  logic [7:0] q;
  logic ok;
  int err_count = 0;
  int n_tests = 0;
  // open-drain wire with pull-up
  wire logic sda = (sda_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;

  always #10 clk = ~clk;

  gvb_core #(.NV_WRITE_CYCLES(NVW)) uut (.clk(clk), .rst(rst), .load_strobe(load_strobe),
    .bank_select_pin_high(sel[1]), .bank_select_pin_low(sel[0]), .address_select_pin(address_select_pin),
    .over_temp(over_temp), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .dac_code(dac_code), .chan_drive_en(chan_drive_en), .nv_busy(nv_busy));
  gvb_master m (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));

  task automatic wrap_up;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      $display("[ERR] %s exp %h got %h", nm, e, g);
      err_count++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // write with ack expected, then wait out the write time
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    m.wr(dev, p, d, ok);
    chk("ack", 16'h1, {15'h0, ok});
    for (int i = 0; i < 400 && nv_busy !== 1'b0; i++) cyc(1);
    if (nv_busy !== 1'b0) begin
      err_count++;
      wrap_up();
    end
  endtask
  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    m.rd(dev, p, q);
    chk("rd", {8'h0, e}, {8'h0, q});
  endtask

  task automatic t_reset;
    rd(8'h60, 8'h10);
    rd(8'h50, 8'h00);
    rd(8'h3B, 8'h80);
    rd(8'h0A, 8'h00);
    chk("dac0", 16'h80, {8'h0, dac_code[0]});
    chk("en", 16'h7FF, {5'h0, chan_drive_en});
  endtask
  task automatic t_pins;
    for (int b = 0; b < 4; b++) begin
      wr(8'h10 + 8'(b), 8'h11 * 8'(b + 1));
      wr(8'h38 + 8'(b), 8'hA0 + 8'(b));
    end
    for (int b = 0; b < 4; b++) begin
      sel <= 2'(b);
      cyc(6);
      chk("dac0", 16'h11 * 16'(b + 1), {8'h0, dac_code[0]});
      chk("dac10", 16'hA0 + 16'(b), {8'h0, dac_code[10]});
    end
  endtask
  task automatic t_latch;
    sel <= 2'h0;
    cyc(6);
    load_strobe <= 1'b0;
    cyc(6);
    sel <= 2'h3;
    cyc(8);
    chk("hold", 16'h11, {8'h0, dac_code[0]});
    rd(8'h57, 8'h03);
    load_strobe <= 1'b1;
    cyc(5);
    chk("rise", 16'h44, {8'h0, dac_code[0]});
    rd(8'h57, 8'h83);
    load_strobe <= 1'b0;
    cyc(6);
    sel <= 2'h1;
    cyc(8);
    chk("fall", 16'h44, {8'h0, dac_code[0]});
    load_strobe <= 1'b1;
  endtask
  task automatic t_soft;
    wr(8'h60, 8'h01);
    cyc(5);
    chk("softa", 16'h11, {8'h0, dac_code[0]});
    wr(8'h50, 8'h02);
    sel <= 2'h0;
    cyc(6);
    chk("softc", 16'h33, {8'h0, dac_code[0]});
    rd(8'h50, 8'h02);
  endtask
  task automatic t_direct;
    wr(8'h60, 8'h02);
    wr(8'h00, 8'h5A);
    cyc(4);
    chk("dir", 16'h5A, {8'h0, dac_code[0]});
    rd(8'h00, 8'h5A);
    wr(8'h06, 8'hC3);
    cyc(4);
    chk("dac6", 16'hC3, {8'h0, dac_code[6]});
    wr(8'h60, 8'h03);
    cyc(4);
    chk("dirx", 16'h5A, {8'h0, dac_code[0]});
    load_strobe <= 1'b0;
    cyc(6);
    wr(8'h0A, 8'hA5);
    cyc(4);
    chk("dirlow", 16'h00, {8'h0, dac_code[10]});
    load_strobe <= 1'b1;
    cyc(5);
    chk("dirrise", 16'hA5, {8'h0, dac_code[10]});
  endtask
  task automatic t_standby;
    wr(8'h51, 8'h01);
    cyc(3);
    chk("stby", 16'h000, {5'h0, chan_drive_en});
    rd(8'h51, 8'h01);
    wr(8'h51, 8'h00);
    cyc(3);
    chk("wake", 16'h7FF, {5'h0, chan_drive_en});
    over_temp <= 1'b1;
    cyc(6);
    chk("hot", 16'h7FE, {5'h0, chan_drive_en});
    over_temp <= 1'b0;
    cyc(6);
    chk("cool", 16'h7FF, {5'h0, chan_drive_en});
  endtask
  task automatic t_addr;
    address_select_pin <= 1'b1;
    cyc(4);
    m.wr(8'hC0, 8'h51, 8'h00, ok);
    chk("nack", 16'h0, {15'h0, ok});
    dev = 8'hC2;
    m.wr(dev, 8'h10, 8'h77, ok);
    chk("ack2", 16'h1, {15'h0, ok});
    chk("nvbusy", 16'h1, {15'h0, nv_busy});
    m.wr(dev, 8'h51, 8'h00, ok);
    chk("busy", 16'h0, {15'h0, ok});
    rd(8'h10, 8'h77);
  endtask

  initial begin
    cyc(5);
    rst <= 1'b0;
    cyc(4);
    t_reset();
    t_pins();
    t_latch();
    t_soft();
    t_direct();
    t_standby();
    t_addr();
    wrap_up();
  end
  initial begin
    cyc(100000);
    err_count++;
    wrap_up();
  end
endmodule // testbench
